/* hdl/dct_pkg.sv */
package dct_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_START    = 8'h00;
    localparam logic [7:0] OFF_FUNC     = 8'h04;
    localparam logic [7:0] OFF_CTRL0    = 8'h08;
    localparam logic [7:0] OFF_CTRL1    = 8'h0c;
    localparam logic [7:0] OFF_CNT0     = 8'h10;
    localparam logic [7:0] OFF_CNT1     = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
    localparam logic [7:0] OFF_CMP_BASE = 8'h20;
    localparam logic [7:0] OFF_CMP_END  = 8'h40;

    // Field positions and widths
    localparam int START_RUN_LSB = 0;
    localparam int START_SEL_LSB = 2;
    localparam int FUNC_MODE_LSB = 0;
    localparam int FUNC_OLSP_BIT = 2;
    localparam int FUNC_OLSN_BIT = 3;
    localparam int CTRL_CLR_LSB  = 0;
    localparam int CTRL_CKS_LSB  = 3;
    localparam int STAT_CH_W     = 5;

    // Counter clear select codes
    localparam logic [2:0] CLR_A    = 3'h1;
    localparam logic [2:0] CLR_B    = 3'h2;
    localparam logic [2:0] CLR_SYNC = 3'h3;
    localparam logic [2:0] CLR_C    = 3'h5;
    localparam logic [2:0] CLR_D    = 3'h6;

    // Function modes
    localparam logic [1:0] MODE_TIMER = 2'h0;

    // Count clock select codes
    localparam logic [2:0] CKS_F1   = 3'h0;
    localparam logic [2:0] CKS_F2   = 3'h1;
    localparam logic [2:0] CKS_F4   = 3'h2;
    localparam logic [2:0] CKS_F8   = 3'h3;
    localparam logic [2:0] CKS_F32  = 3'h4;
    localparam logic [2:0] CKS_EXT  = 3'h5;
    localparam logic [2:0] CKS_40M  = 3'h6;
    localparam logic [2:0] CKS_FAST = 3'h7;

    // Reset values and counter maximum
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [15:0] CMP_RST  = 16'hffff;
    localparam logic [15:0] CNT_MAX  = 16'hffff;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* hdl/dct_chan_if.sv */
`timescale 1ns/1ps
interface dct_chan_if;
    import dct_pkg::*;

    logic             run;
    logic             ssel;
    logic             pwm;
    logic             ols_p;
    logic             ols_n;
    logic             tick;
    logic [2:0]       clr_sel;
    logic [3:0][15:0] cmp;
    logic             wr_en;
    logic [15:0]      wr_data;
    logic             sync_in;
    logic [15:0]      cnt;
    logic [3:0]       pins;
    logic [3:0]       hit;
    logic             ovf;
    logic             clr_src;
    logic             stop;

    modport core (
        input  run, ssel, pwm, ols_p, ols_n, tick, clr_sel, cmp,
        input  wr_en, wr_data, sync_in,
        output cnt, pins, hit, ovf, clr_src, stop
    );

    modport ctl (
        output run, ssel, pwm, ols_p, ols_n, tick, clr_sel, cmp,
        output wr_en, wr_data, sync_in,
        input  cnt, pins, hit, ovf, clr_src, stop
    );
endinterface

/* hdl/dct_chan.sv */
`timescale 1ns/1ps
module dct_chan
    import dct_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    dct_chan_if.core ch
);
    typedef struct packed {
        logic [15:0] cnt;
        logic [3:0]  pins;
    } dct_chan_state_t;

    dct_chan_state_t s;
    dct_chan_state_t next_s;
    logic [3:0]      hit;
    logic            clr_src;
    logic            ovf;
    logic            do_clr;
    logic            counting;

    function automatic logic clr_hit(input logic [2:0] sel,
                                     input logic [3:0] h);
        case (sel)
            CLR_A:   clr_hit = h[0];
            CLR_B:   clr_hit = h[1];
            CLR_C:   clr_hit = h[2];
            CLR_D:   clr_hit = h[3];
            default: clr_hit = 1'b0;
        endcase
    endfunction

    always_comb begin
        next_s   = s;
        counting = ch.run & ch.tick;
        hit      = '0;
        for (int k = 0; k < 4; k++) begin
            hit[k] = counting && (s.cnt == ch.cmp[k]);
        end
        clr_src = clr_hit(ch.clr_sel, hit);
        ovf     = counting && (s.cnt == CNT_MAX) && !clr_src;
        do_clr  = clr_src
                | (ch.run && ch.clr_sel == CLR_SYNC && ch.sync_in);
        if (counting) begin
            next_s.cnt = s.cnt + 16'h0001;
        end
        if (do_clr) begin
            next_s.cnt = CNT_RST;
        end
        if (ch.wr_en) begin
            next_s.cnt = do_clr ? CNT_RST : ch.wr_data;
        end
        next_s.pins = s.pins ^ hit;
        if (!ch.run && ch.pwm) begin
            next_s.pins = {ch.ols_n, ch.ols_p, ch.ols_n, ch.ols_p};
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign ch.cnt     = s.cnt;
    assign ch.pins    = s.pins;
    assign ch.hit     = hit;
    assign ch.ovf     = ovf;
    assign ch.clr_src = clr_src;
    assign ch.stop    = hit[0] & ~ch.ssel;
endmodule

/* hdl/dct_timer.sv */
`timescale 1ns/1ps
module dct_timer
    import dct_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        count_ext_in,
    input  wire logic        onchip_40mhz_clock,
    input  wire logic        fast_onchip_clock,
    output logic [7:0]       timer_output_pin,
    output logic             irq
);
    typedef struct packed {
        logic                  aw_have;
        logic [7:0]            aw_addr;
        logic                  w_have;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic [1:0]            run;
        logic [1:0]            ssel;
        logic [1:0]            mode;
        logic                  ols_p;
        logic                  ols_n;
        logic [1:0][2:0]       clr_sel;
        logic [1:0][2:0]       cks;
        logic [1:0][3:0][15:0] cmp;
        logic [1:0]            pend_wr;
        logic [15:0]           pend_data;
        logic [2*STAT_CH_W-1:0] stat;
        logic [2*STAT_CH_W-1:0] mask;
        logic                  irq;
        logic [4:0]            pre;
        logic [2:0]            s1;
        logic [2:0]            s2;
        logic [2:0]            s3;
        logic [2:0]            lvl;
    } dct_state_t;

    dct_state_t             s;
    dct_state_t             next_s;
    dct_chan_if             chi[2] ();
    logic [1:0][15:0]       cnt_w;
    logic [1:0][3:0]        hit_w;
    logic [1:0]             ovf_w;
    logic [1:0]             clr_w;
    logic [1:0]             stop_w;
    logic [1:0][3:0]        pins_w;
    logic [2:0]             edge_w;
    logic [1:0]             tick_w;
    logic                   wr_fire;
    logic [7:0]             wa;
    logic [7:0]             ra;
    logic [31:0]            wd;
    logic [31:0]            rd;
    logic [2*STAT_CH_W-1:0] ev;
    logic [2*STAT_CH_W-1:0] clr_bits;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        for (int b = 0; b < 4; b++) begin
            merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
    endfunction

    function automatic logic tick_of(input logic [2:0] sel,
                                     input logic [4:0] pre,
                                     input logic [2:0] edges);
        case (sel)
            CKS_F1:   tick_of = 1'b1;
            CKS_F2:   tick_of = pre[0];
            CKS_F4:   tick_of = &pre[1:0];
            CKS_F8:   tick_of = &pre[2:0];
            CKS_F32:  tick_of = &pre;
            CKS_EXT:  tick_of = edges[0];
            CKS_40M:  tick_of = edges[1];
            CKS_FAST: tick_of = edges[2];
        endcase
    endfunction

    function automatic logic is_cmp(input logic [7:0] a);
        is_cmp = (a >= OFF_CMP_BASE) && (a < OFF_CMP_END);
    endfunction

    // Channel cores
    for (genvar g = 0; g < 2; g++) begin : gen_ch
        dct_chan u_ch (
            .clk     (clk),
            .sys_rst (sys_rst),
            .ch      (chi[g])
        );
        assign chi[g].run     = s.run[g];
        assign chi[g].ssel    = s.ssel[g];
        assign chi[g].pwm     = (s.mode != MODE_TIMER);
        assign chi[g].ols_p   = s.ols_p;
        assign chi[g].ols_n   = s.ols_n;
        assign chi[g].tick    = tick_w[g];
        assign chi[g].clr_sel = s.clr_sel[g];
        assign chi[g].cmp     = s.cmp[g];
        assign chi[g].wr_en   = s.pend_wr[g];
        assign chi[g].wr_data = s.pend_data;
        assign chi[g].sync_in = clr_w[1-g];
        assign cnt_w[g]       = chi[g].cnt;
        assign hit_w[g]       = chi[g].hit;
        assign ovf_w[g]       = chi[g].ovf;
        assign clr_w[g]       = chi[g].clr_src;
        assign stop_w[g]      = chi[g].stop;
        assign pins_w[g]      = chi[g].pins;
        assign tick_w[g]      = tick_of(s.cks[g], s.pre, edge_w);
    end

    // Tick inputs count once second and third stage agree
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            edge_w[i] = (s.s2[i] == s.s3[i]) && s.s3[i] && !s.lvl[i];
        end
    end

    always_comb begin
        next_s   = s;
        wa       = {s.aw_addr[7:2], 2'h0};
        ra       = {s_axi_araddr[7:2], 2'h0};
        wd       = '0;
        rd       = '0;
        clr_bits = '0;
        ev       = {ovf_w[1], hit_w[1], ovf_w[0], hit_w[0]};

        next_s.pre = s.pre + 5'h01;
        next_s.s1  = {fast_onchip_clock, onchip_40mhz_clock,
                      count_ext_in};
        next_s.s2  = s.s1;
        next_s.s3  = s.s2;
        for (int i = 0; i < 3; i++) begin
            if (s.s2[i] == s.s3[i]) begin
                next_s.lvl[i] = s.s3[i];
            end
        end

        next_s.pend_wr = '0;
        for (int i = 0; i < 2; i++) begin
            if (stop_w[i]) begin
                next_s.run[i] = 1'b0;
            end
        end

        // Write address and data channels
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_have = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_have = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s_axi_bready && s.bvalid) begin
            next_s.bvalid = 1'b0;
        end

        wr_fire = s.aw_have && s.w_have && !s.bvalid;
        if (wr_fire) begin
            next_s.aw_have = 1'b0;
            next_s.w_have  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RESP_OKAY;
            case (wa)
                OFF_START: begin
                    if (s.w_strb[0]) begin
                        for (int i = 0; i < 2; i++) begin
                            if (s.w_data[START_RUN_LSB+i]) begin
                                next_s.run[i] = 1'b1;
                            end else if (s.ssel[i]) begin
                                next_s.run[i] = 1'b0;
                            end
                            // Run 0 with old select 0 leaves run unchanged
                            next_s.ssel[i] =
                                s.w_data[START_SEL_LSB+i];
                        end
                    end
                end
                OFF_FUNC: begin
                    if (s.w_strb[0]) begin
                        next_s.mode  = s.w_data[FUNC_MODE_LSB +: 2];
                        next_s.ols_p = s.w_data[FUNC_OLSP_BIT];
                        next_s.ols_n = s.w_data[FUNC_OLSN_BIT];
                    end
                end
                OFF_CTRL0, OFF_CTRL1: begin
                    if (s.w_strb[0]) begin
                        next_s.clr_sel[wa[2]] =
                            s.w_data[CTRL_CLR_LSB +: 3];
                        next_s.cks[wa[2]] = s.w_data[CTRL_CKS_LSB +: 3];
                    end
                end
                OFF_CNT0, OFF_CNT1: begin
                    wd = merge({16'h0, cnt_w[wa[2]]}, s.w_data,
                               s.w_strb);
                    // Write lands one cycle later
                    next_s.pend_wr[wa[2]] = 1'b1;
                    next_s.pend_data      = wd[15:0];
                end
                OFF_IRQ_STAT: begin
                    wd       = merge('0, s.w_data, s.w_strb);
                    clr_bits = wd[2*STAT_CH_W-1:0];
                end
                OFF_IRQ_MASK: begin
                    wd = merge({22'h0, s.mask}, s.w_data, s.w_strb);
                    next_s.mask = wd[2*STAT_CH_W-1:0];
                end
                default: begin
                    if (is_cmp(wa)) begin
                        wd = merge({16'h0, s.cmp[wa[4]][wa[3:2]]},
                                   s.w_data, s.w_strb);
                        next_s.cmp[wa[4]][wa[3:2]] = wd[15:0];
                    end else begin
                        next_s.bresp = RESP_SLVERR;
                    end
                end
            endcase
        end

        // Event set wins over software clear
        next_s.stat = (s.stat & ~clr_bits) | ev;
        next_s.irq  = |(next_s.stat & s.mask);

        // Read channel
        if (s_axi_rready && s.rvalid) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            case (ra)
                OFF_START: begin
                    rd[START_RUN_LSB +: 2] = s.run;
                    rd[START_SEL_LSB +: 2] = s.ssel;
                end
                OFF_FUNC: begin
                    rd[FUNC_MODE_LSB +: 2] = s.mode;
                    rd[FUNC_OLSP_BIT]      = s.ols_p;
                    rd[FUNC_OLSN_BIT]      = s.ols_n;
                end
                OFF_CTRL0, OFF_CTRL1: begin
                    rd[CTRL_CLR_LSB +: 3] = s.clr_sel[ra[2]];
                    rd[CTRL_CKS_LSB +: 3] = s.cks[ra[2]];
                end
                OFF_CNT0, OFF_CNT1: begin
                    rd[15:0] = cnt_w[ra[2]];
                end
                OFF_IRQ_STAT: begin
                    rd[2*STAT_CH_W-1:0] = s.stat;
                end
                OFF_IRQ_MASK: begin
                    rd[2*STAT_CH_W-1:0] = s.mask;
                end
                default: begin
                    if (is_cmp(ra)) begin
                        rd[15:0] = s.cmp[ra[4]][ra[3:2]];
                    end else begin
                        next_s.rresp = RESP_SLVERR;
                    end
                end
            endcase
            next_s.rdata = rd;
        end

        next_s.awready = !next_s.aw_have && !next_s.bvalid;
        next_s.wready  = !next_s.w_have && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s     <= '0;
            s.cmp <= {8{CMP_RST}};
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready    = s.awready;
    assign s_axi_wready     = s.wready;
    assign s_axi_bvalid     = s.bvalid;
    assign s_axi_bresp      = s.bresp;
    assign s_axi_arready    = s.arready;
    assign s_axi_rvalid     = s.rvalid;
    assign s_axi_rdata      = s.rdata;
    assign s_axi_rresp      = s.rresp;
    assign irq              = s.irq;
    assign timer_output_pin = {pins_w[1], pins_w[0]};
endmodule

/* verification/dct_timer_properties.sv */
`timescale 1ns/1ps
module dct_timer_properties
    import dct_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic [7:0] wa;
    logic [7:0] ra;

    // Addresses of the transfers under way
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wa <= 8'h00;
            ra <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready)
                wa <= s_axi_awaddr;
            if (s_axi_arvalid && s_axi_arready)
                ra <= s_axi_araddr;
        end
    end

    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write response not on time");

    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped");

    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read response not on time");

    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data changed while waiting");

    property p_wr_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wr_block: assert property (p_wr_block)
        else $error("write accepted while response pending");

    property p_wr_reopen;
        s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready
            && !s_axi_bvalid;
    endproperty
    a_wr_reopen: assert property (p_wr_reopen)
        else $error("write channel not reopened");

    property p_rd_reopen;
        s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid;
    endproperty
    a_rd_reopen: assert property (p_rd_reopen)
        else $error("read channel not reopened");

    property p_rd_err;
        $rose(s_axi_rvalid) |-> ((s_axi_rresp == RESP_SLVERR) == (ra >= 8'h40))
            && (s_axi_rresp == RESP_OKAY || s_axi_rdata == 32'h0);
    endproperty
    a_rd_err: assert property (p_rd_err)
        else $error("read response code wrong");

    property p_wr_err;
        $rose(s_axi_bvalid) |-> (s_axi_bresp == RESP_SLVERR) == (wa >= 8'h40);
    endproperty
    a_wr_err: assert property (p_wr_err)
        else $error("write response code wrong");

    c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_rd_ok: cover property (s_axi_rvalid && s_axi_rresp == RESP_OKAY);
    c_irq: cover property ($rose(irq));
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
        end \
    end
module tb_top
    import dct_pkg::*;
    ;
    logic        clk, sys_rst, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, ext_in, osc40;
    logic        fast, irq;
    logic [7:0]  awaddr, araddr, cyc, pins;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb, st_model;
    logic [1:0]  bresp, rresp, r;
    int          mismatches, checks_done, seed, i, k, e, tol;
    int          div_q[$] = '{1, 2, 4, 8, 32, 16, 8, 8};
    logic [2:0]  clr_q[$] = '{CLR_B, CLR_C, CLR_D, 3'h0, 3'h4, 3'h7};

    dct_timer dut_u (
        .clk(clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .count_ext_in(ext_in), .onchip_40mhz_clock(osc40),
        .fast_onchip_clock(fast), .timer_output_pin(pins), .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Slow count sources: ext period 16 clk, others 8 clk
    always @(posedge clk) begin
        cyc <= cyc + 8'h01;
        ext_in <= cyc[3];
        osc40 <= cyc[2];
        fast <= cyc[2];
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] resp);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bready && bvalid) begin
                resp = bresp;
                bready <= 1'b0;
            end
        end while (awvalid || wvalid || bready);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] resp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rready && rvalid) begin
                v = rdata;
                resp = rresp;
                rready <= 1'b0;
            end
        end while (arvalid || rready);
    endtask

    task automatic wok(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] resp;
        wr(a, v, resp);
        `CHK("bresp", RESP_OKAY, resp)
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] v;
        logic [1:0]  resp;
        rd(a, v, resp);
        `CHK("rresp", RESP_OKAY, resp)
        `CHK($sformatf("reg %h", a), x, v)
    endtask

    // Start register model: run 0 stops only if the old select was 1
    function automatic logic [3:0] st_next(logic [3:0] cur, logic [3:0] w);
        logic [3:0] n;
        n = w;
        for (int c = 0; c < 2; c++)
            if (!w[c] && !cur[2 + c])
                n[c] = cur[c];
        return n;
    endfunction

    task automatic start_wr(input logic [3:0] w);
        st_model = st_next(st_model, w);
        wok(OFF_START, {28'h0, w});
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        summarize();
    end

    initial begin
        seed = 45;
        mismatches = 0;
        checks_done = 0;
        cyc = 8'h00;
        st_model = 4'h0;
        sys_rst = 1'b1;
        {awaddr, araddr, wdata} = 48'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {ext_in, osc40, fast} = 3'h0;
        wstrb = 4'hf;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 8; i++)
            rchk(OFF_CMP_BASE + 8'(4 * i), 32'hffff);
        rchk(OFF_START, 32'h0);
        rchk(OFF_IRQ_MASK, 32'h0);
        for (i = 0; i < 8; i++) begin
            d = $random(seed);
            wok(OFF_CMP_BASE + 8'(4 * i), d);
            rchk(OFF_CMP_BASE + 8'(4 * i), {16'h0, d[15:0]});
            wok(OFF_CMP_BASE + 8'(4 * i), 32'hffff);
            k = $random(seed);
            wr(8'h40 | {k[5:0], 2'b00}, k, r);
            `CHK("bresp bad", RESP_SLVERR, r)
            rd(8'h40 | {k[5:0], 2'b00}, d, r);
            `CHK("rresp bad", RESP_SLVERR, r)
            `CHK("rdata bad", 32'h0, d)
        end
        // Stop handshake on each channel
        for (k = 0; k < 2; k++) begin
            start_wr(4'h1 << k);
            rchk(OFF_START, {28'h0, st_model});
            start_wr(4'h0);
            rchk(OFF_START, {28'h0, st_model});
            start_wr(4'h4 << k);
            rchk(OFF_START, {28'h0, st_model});
            start_wr(4'h4 << k);
            rchk(OFF_START, {28'h0, st_model});
            start_wr(4'h0);
        end
        // Stop at match A with clear on A
        wok(OFF_CNT0, 32'h0);
        wok(OFF_CMP_BASE, 32'd20);
        wok(OFF_CTRL0, {26'h0, CKS_F1, CLR_A});
        start_wr(4'h1);
        repeat (40) @(posedge clk);
        st_model[0] = 1'b0;
        rchk(OFF_START, {28'h0, st_model});
        rchk(OFF_CNT0, 32'h0);
        `CHK("pins", 8'h01, pins)
        rchk(OFF_IRQ_STAT, 32'h1);
        `CHK("irq", 1'b0, irq)
        wok(OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        wok(OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        rchk(OFF_IRQ_STAT, 32'h0);
        `CHK("pins hold", 8'h01, pins)
        wok(OFF_CMP_BASE, 32'h0);
        start_wr(4'h5);
        wok(OFF_CNT0, 32'h1234);
        rchk(OFF_CNT0, 32'h0);
        start_wr(4'h4);
        // Clear select codes, channel 1 on sync clear
        for (i = 1; i < 4; i++)
            wok(OFF_CMP_BASE + 8'(4 * i), 32'd4);
        wok(OFF_CMP_BASE, 32'hffff);
        wok(OFF_CTRL1, {26'h0, CKS_F1, CLR_SYNC});
        for (i = 0; i < 6; i++) begin
            wok(OFF_CTRL0, {26'h0, CKS_F1, clr_q[i]});
            wok(OFF_CNT0, 32'h0);
            wok(OFF_CNT1, 32'h0);
            start_wr(4'hf);
            repeat (40) @(posedge clk);
            start_wr(4'hc);
            rd(OFF_CNT0, d, r);
            `CHK("clear ch0", i < 3, d <= 4)
            rd(OFF_CNT1, d, r);
            `CHK("sync ch1", i < 3, d <= 4)
        end
        // Count clock select on channel 1
        for (i = 0; i < 8; i++) begin
            wok(OFF_CTRL1, {26'h0, 3'(i), 3'h0});
            wok(OFF_CNT1, 32'h0);
            start_wr(4'ha);
            repeat (160) @(posedge clk);
            start_wr(4'h8);
            rd(OFF_CNT1, d, r);
            e = 166 / div_q[i];
            tol = 2 + 8 / div_q[i];
            `CHK("cks", 1'b1, (d + tol >= e) && (d <= e + tol))
        end
        wok(OFF_FUNC, 32'h5);
        repeat (2) @(posedge clk);
        `CHK("pwm pins", 8'h55, pins)
        wok(OFF_FUNC, 32'ha);
        repeat (2) @(posedge clk);
        `CHK("pwm pins", 8'haa, pins)
        rchk(OFF_FUNC, 32'ha);
        d = $random(seed);
        wok(OFF_CNT1, d);
        rchk(OFF_CNT1, {16'h0, d[15:0]});
        summarize();
    end
endmodule

bind dct_timer dct_timer_properties chk_u (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq)
);
